// ===== rtl/varm_consts.svh
// Named constants for the vector accumulator, rounding and multiply slice.
// Assumes inclusion by bare name from the slice's design file.
`ifndef VARM_CONSTS_SVH
`define VARM_CONSTS_SVH

`define VARM_LANES 8
`define VARM_HW 16
`define VARM_VEC_W 128
`define VARM_ACC_W 48
`define VARM_PROD_W 32
`define VARM_BACC_W 24
`define VARM_BYTE_W 8
`define VARM_REG_W 5
`define VARM_ELEM_W 4
`define VARM_ELEM_BCAST 3
`define VARM_SEL_W 3
`define VARM_FRAC_SHIFT 1
`define VARM_SHIFT_BIT 0
`define VARM_THIRD_HI 4'h0
`define VARM_THIRD_MID 4'h1
`define VARM_THIRD_LO 4'h2
`define VARM_MID_LSB 16
`define VARM_HI_LSB 32
`define VARM_FRAC_RND 48'h000000008000
`define VARM_QUANT_RND 48'h0000001F0000
`define VARM_QUANT_LSB 21
`define VARM_S16_MAX 16'h7FFF
`define VARM_S16_MIN 16'h8000
`define VARM_U16_MAX 16'hFFFF
`define VARM_U8_MAX 8'hFF
`define VARM_S12_MAX 12'h7FF
`define VARM_S12_MIN 12'h800
`define VARM_S12_W 12

`endif

// ===== rtl/varm_pkg.sv
// Types for the vector accumulator, rounding and multiply slice.
// Assumes nothing beyond the constants header.
package varm_pkg;

  typedef enum logic [9:0] {
    VARM_OP_ACC_SAVE_AND_LOAD = 10'h001,
    VARM_OP_ROUND_IF_POSITIVE = 10'h002,
    VARM_OP_ROUND_IF_NEGATIVE = 10'h004,
    VARM_OP_ROUND_UNCONDITIONAL = 10'h008,
    VARM_OP_ROUND_BYTES = 10'h010,
    VARM_OP_MULT_SIGNED_FRACTION = 10'h020,
    VARM_OP_MULT_ACC_SIGNED_FRACTION = 10'h040,
    VARM_OP_MULT_UNSIGNED_FRACTION = 10'h080,
    VARM_OP_MULT_ACC_UNSIGNED_FRACTION = 10'h100,
    VARM_OP_MULT_QUANTIZE = 10'h200
  } varm_op_e;

  typedef logic [47:0] varm_acc_t;

endpackage

// ===== rtl/varm_top.sv
// Accumulator save/load, rounding and halfword fraction/quantize multiply slice.
// Assumes the issue pipeline supplies decoded op and the two read vectors,
// and that the vector register file takes the write-back port.
`include "varm_consts.svh"

module varm_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic issue_valid,
  input wire varm_pkg::varm_op_e issue_op,
  input wire logic [`VARM_REG_W-1:0] dest_reg_field,
  input wire logic [`VARM_REG_W-1:0] src_reg_field,
  input wire logic [`VARM_REG_W-1:0] third_operand_field,
  input wire logic [`VARM_ELEM_W-1:0] issue_element,
  input wire logic [`VARM_VEC_W-1:0] src_data,
  input wire logic [`VARM_VEC_W-1:0] third_data,
  output logic wb_valid,
  output logic [`VARM_REG_W-1:0] wb_reg,
  output logic [`VARM_VEC_W-1:0] wb_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturation helpers

  function automatic logic [`VARM_HW-1:0] clamp_s16(input varm_pkg::varm_acc_t a);
    logic [`VARM_PROD_W-1:0] v;
    v = a[`VARM_ACC_W-1:`VARM_MID_LSB];
    if ((&v[`VARM_PROD_W-1:`VARM_HW-1]) || !(|v[`VARM_PROD_W-1:`VARM_HW-1]))
      clamp_s16 = v[`VARM_HW-1:0];
    else if (v[`VARM_PROD_W-1])
      clamp_s16 = `VARM_S16_MIN;
    else
      clamp_s16 = `VARM_S16_MAX;
  endfunction

  function automatic logic [`VARM_HW-1:0] clamp_u16(input varm_pkg::varm_acc_t a);
    if (a[`VARM_ACC_W-1])
      clamp_u16 = '0;
    else if (|a[`VARM_ACC_W-2:`VARM_HI_LSB])
      clamp_u16 = `VARM_U16_MAX;
    else
      clamp_u16 = a[`VARM_HI_LSB-1:`VARM_MID_LSB];
  endfunction

  function automatic logic [`VARM_BYTE_W-1:0] clamp_u8(input logic [`VARM_BACC_W-1:0] b);
    if (b[`VARM_BACC_W-1])
      clamp_u8 = '0;
    else if (|b[`VARM_BACC_W-2:`VARM_BYTE_W])
      clamp_u8 = `VARM_U8_MAX;
    else
      clamp_u8 = b[`VARM_BYTE_W-1:0];
  endfunction

  function automatic logic [`VARM_HW-1:0] clamp_s12(input varm_pkg::varm_acc_t a);
    logic [`VARM_ACC_W-`VARM_QUANT_LSB-1:0] v;
    logic [`VARM_S12_W-1:0] r;
    v = a[`VARM_ACC_W-1:`VARM_QUANT_LSB];
    if ((&v[`VARM_ACC_W-`VARM_QUANT_LSB-1:`VARM_S12_W-1])
        || !(|v[`VARM_ACC_W-`VARM_QUANT_LSB-1:`VARM_S12_W-1]))
      r = v[`VARM_S12_W-1:0];
    else if (v[`VARM_ACC_W-`VARM_QUANT_LSB-1])
      r = `VARM_S12_MIN;
    else
      r = `VARM_S12_MAX;
    clamp_s12 = {{(`VARM_HW-`VARM_S12_W){r[`VARM_S12_W-1]}}, r};
  endfunction

  // Broadcast one halfword when the top element bit is set, else lane-wise
  function automatic logic [`VARM_HW-1:0] sel_third(
    input logic [`VARM_VEC_W-1:0] vec,
    input logic [`VARM_ELEM_W-1:0] elem,
    input int lane
  );
    logic [`VARM_SEL_W-1:0] idx;
    idx = elem[`VARM_ELEM_BCAST] ? elem[`VARM_SEL_W-1:0] : `VARM_SEL_W'(lane);
    sel_third = vec[idx*`VARM_HW +: `VARM_HW];
  endfunction

  function automatic varm_pkg::varm_acc_t sext_hw(input logic [`VARM_HW-1:0] h);
    sext_hw = {{(`VARM_ACC_W-`VARM_HW){h[`VARM_HW-1]}}, h};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // First execute stage: operand capture

  logic ex_valid_r;
  varm_pkg::varm_op_e ex_op_r;
  logic [`VARM_REG_W-1:0] ex_dest_r;
  logic ex_shift_r;
  logic [`VARM_ELEM_W-1:0] ex_elem_r;
  logic [`VARM_VEC_W-1:0] ex_src_r;
  logic [`VARM_VEC_W-1:0] ex_third_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ex_valid_r <= 1'b0;
      ex_op_r <= varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD;
      ex_dest_r <= '0;
      ex_shift_r <= 1'b0;
      ex_elem_r <= '0;
      ex_src_r <= '0;
      ex_third_r <= '0;
    end
    else
    begin
      ex_valid_r <= issue_valid;
      ex_op_r <= issue_op;
      ex_dest_r <= dest_reg_field;
      ex_shift_r <= src_reg_field[`VARM_SHIFT_BIT];
      ex_elem_r <= issue_element;
      ex_src_r <= src_data;
      ex_third_r <= third_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second execute stage control

  logic m2_valid_r;
  varm_pkg::varm_op_e m2_op_r;
  logic [`VARM_REG_W-1:0] m2_dest_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      m2_valid_r <= 1'b0;
      m2_op_r <= varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD;
      m2_dest_r <= '0;
    end
    else
    begin
      m2_valid_r <= ex_valid_r;
      m2_op_r <= ex_op_r;
      m2_dest_r <= ex_dest_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-back stage control

  logic wb_valid_r;
  logic [`VARM_REG_W-1:0] wb_reg_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wb_valid_r <= 1'b0;
      wb_reg_r <= '0;
    end
    else
    begin
      wb_valid_r <= m2_valid_r;
      wb_reg_r <= m2_dest_r;
    end
  end

  assign wb_valid = wb_valid_r;
  assign wb_reg = wb_reg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane accumulator datapath

  genvar gi;
  generate
    for (gi = 0; gi < `VARM_LANES; gi++)
    begin : g_lane
      varm_pkg::varm_acc_t acc_r;
      varm_pkg::varm_acc_t acc_nxt;
      logic acc_we;
      logic [`VARM_HW-1:0] save_r;
      logic [`VARM_HW-1:0] save_nxt;
      logic [`VARM_HW-1:0] wb_lane_r;
      logic [`VARM_HW-1:0] wb_lane_nxt;
      logic [`VARM_HW-1:0] s_h;
      logic [`VARM_HW-1:0] t_h;
      logic signed [`VARM_PROD_W-1:0] prod;
      varm_pkg::varm_acc_t prod_x;
      varm_pkg::varm_acc_t frac;
      varm_pkg::varm_acc_t addend;
      varm_pkg::varm_acc_t quant;
      logic acc_pos;
      logic acc_neg;
      logic [`VARM_SEL_W-1:0] be;
      logic signed [`VARM_BACC_W-1:0] b_hi;
      logic signed [`VARM_BACC_W-1:0] b_lo;
      logic signed [`VARM_BACC_W-1:0] b_rnd;

      always_comb
      begin
        s_h = ex_src_r[gi*`VARM_HW +: `VARM_HW];
        t_h = sel_third(ex_third_r, ex_elem_r, gi);
        prod = $signed(s_h) * $signed(t_h);
        prod_x = {{(`VARM_ACC_W-`VARM_PROD_W){prod[`VARM_PROD_W-1]}}, prod};
        frac = $signed(prod_x) >>> `VARM_FRAC_SHIFT;
        addend = ex_shift_r ? (sext_hw(t_h) << `VARM_MID_LSB) : sext_hw(t_h);
        acc_neg = acc_r[`VARM_ACC_W-1];
        acc_pos = !acc_neg && (|acc_r);
        be = ex_elem_r[`VARM_SEL_W-1:0];
        b_rnd = (be == 3'h0) ? '0 : (`VARM_BACC_W'(1) << (be - 3'h1));
        b_hi = ($signed(acc_r[`VARM_ACC_W-1:`VARM_BACC_W]) + b_rnd) >>> be;
        b_lo = ($signed(acc_r[`VARM_BACC_W-1:0]) + b_rnd) >>> be;
        acc_nxt = acc_r;
        acc_we = 1'b0;
        save_nxt = save_r;
        unique case (ex_op_r)
          varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD:
          begin
            acc_we = 1'b1;
            unique case (ex_elem_r)
              `VARM_THIRD_HI:
              begin
                save_nxt = acc_r[`VARM_ACC_W-1:`VARM_HI_LSB];
                acc_nxt[`VARM_ACC_W-1:`VARM_HI_LSB] = s_h;
              end
              `VARM_THIRD_MID:
              begin
                save_nxt = acc_r[`VARM_HI_LSB-1:`VARM_MID_LSB];
                acc_nxt[`VARM_HI_LSB-1:`VARM_MID_LSB] = s_h;
              end
              `VARM_THIRD_LO:
              begin
                save_nxt = acc_r[`VARM_MID_LSB-1:0];
                acc_nxt[`VARM_MID_LSB-1:0] = s_h;
              end
              default:
              begin
                acc_we = 1'b0;
                save_nxt = '0;
              end
            endcase
          end
          varm_pkg::VARM_OP_ROUND_IF_POSITIVE:
          begin
            acc_we = acc_pos;
            acc_nxt = acc_r + addend;
          end
          varm_pkg::VARM_OP_ROUND_IF_NEGATIVE:
          begin
            acc_we = acc_neg;
            acc_nxt = acc_r + addend;
          end
          varm_pkg::VARM_OP_ROUND_UNCONDITIONAL:
          begin
            acc_we = 1'b1;
            acc_nxt = acc_r + addend;
          end
          varm_pkg::VARM_OP_ROUND_BYTES:
          begin
            acc_we = 1'b1;
            acc_nxt = {b_hi, b_lo};
          end
          varm_pkg::VARM_OP_MULT_SIGNED_FRACTION,
          varm_pkg::VARM_OP_MULT_UNSIGNED_FRACTION:
          begin
            acc_we = 1'b1;
            acc_nxt = frac + `VARM_FRAC_RND;
          end
          varm_pkg::VARM_OP_MULT_ACC_SIGNED_FRACTION:
          begin
            acc_we = 1'b1;
            acc_nxt = acc_r + frac + `VARM_FRAC_RND;
          end
          varm_pkg::VARM_OP_MULT_ACC_UNSIGNED_FRACTION:
          begin
            acc_we = 1'b1;
            acc_nxt = acc_r + frac;
          end
          varm_pkg::VARM_OP_MULT_QUANTIZE:
          begin
            acc_we = 1'b1;
            acc_nxt = prod_x << `VARM_MID_LSB;
          end
          default:
          begin
            acc_we = 1'b0;
          end
        endcase
        if (!ex_valid_r)
          acc_we = 1'b0;
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          acc_r <= '0;
        else if (acc_we)
          acc_r <= acc_nxt;
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          save_r <= '0;
        else
          save_r <= save_nxt;
      end

      always_comb
      begin
        quant = acc_r[`VARM_ACC_W-1] ? (acc_r + `VARM_QUANT_RND) : acc_r;
        wb_lane_nxt = '0;
        unique case (m2_op_r)
          varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD:
            wb_lane_nxt = save_r;
          varm_pkg::VARM_OP_ROUND_IF_POSITIVE,
          varm_pkg::VARM_OP_ROUND_IF_NEGATIVE,
          varm_pkg::VARM_OP_ROUND_UNCONDITIONAL:
            wb_lane_nxt = clamp_s16(acc_r);
          varm_pkg::VARM_OP_ROUND_BYTES:
            wb_lane_nxt = {clamp_u8(acc_r[`VARM_ACC_W-1:`VARM_BACC_W]),
                           clamp_u8(acc_r[`VARM_BACC_W-1:0])};
          varm_pkg::VARM_OP_MULT_SIGNED_FRACTION,
          varm_pkg::VARM_OP_MULT_ACC_SIGNED_FRACTION:
            wb_lane_nxt = clamp_s16(acc_r);
          varm_pkg::VARM_OP_MULT_UNSIGNED_FRACTION,
          varm_pkg::VARM_OP_MULT_ACC_UNSIGNED_FRACTION:
            wb_lane_nxt = clamp_u16(acc_r);
          varm_pkg::VARM_OP_MULT_QUANTIZE:
            wb_lane_nxt = clamp_s12(quant);
          default:
            wb_lane_nxt = '0;
        endcase
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          wb_lane_r <= '0;
        else if (m2_valid_r)
          wb_lane_r <= wb_lane_nxt;
      end

      assign wb_data[gi*`VARM_HW +: `VARM_HW] = wb_lane_r;
    end
  endgenerate

endmodule

// ===== verification/varm_assertions.sv
// Port checker for the accumulator, rounding and multiply slice.
// Assumes binding into varm_top: one clock, reset async active high.
module varm_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic issue_valid,
  input wire varm_pkg::varm_op_e issue_op,
  input wire logic [4:0] dest_reg_field,
  input wire logic [3:0] issue_element,
  input wire logic [127:0] src_data,
  input wire logic [127:0] third_data,
  input wire logic wb_valid,
  input wire logic [4:0] wb_reg,
  input wire logic [127:0] wb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  lat_wb_a: assert property (issue_valid |-> ##3 wb_valid)
    else $error("write-back strobe late or missing");
  wb_cause_a: assert property (wb_valid |-> $past(issue_valid, 3))
    else $error("write-back strobe without an issue");
  wb_dest_a: assert property (
    issue_valid |-> ##3 wb_reg == $past(dest_reg_field, 3))
    else $error("write-back register wrong");
  wb_hold_a: assert property (!wb_valid |-> $stable(wb_data))
    else $error("write-back data moved without a strobe");
  save_elem_a: assert property (
    issue_valid && issue_op == varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD
    && issue_element > 4'h2 |-> ##3 wb_data == '0)
    else $error("illegal save element wrote data");
  mulf_zero_a: assert property (
    issue_valid && issue_op == varm_pkg::VARM_OP_MULT_SIGNED_FRACTION
    && src_data == '0 |-> ##3 wb_data == '0)
    else $error("zero signed product not zero");
  mulu_zero_a: assert property (
    issue_valid && issue_op == varm_pkg::VARM_OP_MULT_UNSIGNED_FRACTION
    && third_data == '0 |-> ##3 wb_data == '0)
    else $error("zero unsigned product not zero");
  qnt_range_a: assert property (
    issue_valid && issue_op == varm_pkg::VARM_OP_MULT_QUANTIZE |-> ##3
    (wb_data[15:11] == 5'h00 || wb_data[15:11] == 5'h1F))
    else $error("quantize result outside twelve bits");
  save_c: cover property (issue_valid && issue_op == varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD);
  quant_c: cover property (issue_valid && issue_op == varm_pkg::VARM_OP_MULT_QUANTIZE);
  pair_c: cover property (issue_valid [*2]);
endmodule

bind varm_top varm_checker i_varm_checker (.clk_sys(clk_sys), .rst(rst),
  .issue_valid(issue_valid), .issue_op(issue_op), .dest_reg_field(dest_reg_field),
  .issue_element(issue_element), .src_data(src_data), .third_data(third_data),
  .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data));

// ===== verification/varm_vrf_model.sv
// Vector register file model on the write-back side of the slice.
// Assumes one register write per write-back strobe.
module varm_vrf_model (
  input wire logic clk_sys,
  input wire logic wb_valid,
  input wire logic [4:0] wb_reg,
  input wire logic [127:0] wb_data,
  input wire logic [4:0] rd_reg,
  output logic [127:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] regs_r [32];
  always_ff @(posedge clk_sys)
  begin
    if (wb_valid)
    begin
      regs_r[wb_reg] <= wb_data;
    end
  end
  assign rd_data = regs_r[rd_reg];
endmodule

// ===== verification/vector_acc_round_multiply_tb.sv
// Self-checking bench for the accumulator, rounding and multiply slice.
// Assumes varm_top with the register file model on its write-back port.
module vector_acc_round_multiply_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  varm_pkg::varm_op_e issue_op = varm_pkg::VARM_OP_ACC_SAVE_AND_LOAD;
  logic [4:0] dest_reg_field = '0;
  logic [4:0] src_reg_field = '0;
  logic [4:0] third_operand_field = '0;
  logic [3:0] issue_element = '0;
  logic [127:0] src_data = '0;
  logic [127:0] third_data = '0;
  logic [4:0] rd_reg = '0;
  logic wb_valid;
  logic [4:0] wb_reg;
  logic [127:0] wb_data;
  logic [127:0] rd_data;
  int mismatches = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  varm_top i_varm_top (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
    .issue_op(issue_op), .dest_reg_field(dest_reg_field), .src_reg_field(src_reg_field),
    .third_operand_field(third_operand_field), .issue_element(issue_element),
    .src_data(src_data), .third_data(third_data), .wb_valid(wb_valid), .wb_reg(wb_reg),
    .wb_data(wb_data));
  varm_vrf_model i_varm_vrf_model (.clk_sys(clk_sys), .wb_valid(wb_valid), .wb_reg(wb_reg),
    .wb_data(wb_data), .rd_reg(rd_reg), .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Op index is the one-hot bit position
  task automatic issue(input logic [3:0] i, input logic [3:0] el, input logic sf,
    input logic [15:0] s, input logic [127:0] t, input logic [4:0] d);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_op <= varm_pkg::varm_op_e'(10'h001 << i);
    issue_element <= el;
    src_reg_field <= {4'h0, sf};
    dest_reg_field <= d;
    third_operand_field <= d;
    src_data <= {8{s}};
    third_data <= t;
  endtask
  task automatic peek(input logic [4:0] r, input logic [127:0] e);
    @(negedge clk_sys);
    rd_reg = r;
    #1;
    check(rd_data, e);
  endtask
  // Word: op, element, shift, source, third, expected lane
  task automatic run(input logic [59:0] w);
    int n;
    n = 0;
    issue(w[59:56], w[55:52], w[48], w[47:32], {8{w[31:16]}}, {1'b0, w[59:56]});
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (wb_valid !== 1'b1 && n < 8);
    check(128'(n), 128'h3);
    check(128'(wb_reg), 128'(w[59:56]));
    check(wb_data, {8{w[15:0]}});
    peek({1'b0, w[59:56]}, {8{w[15:0]}});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_save;
    run(60'h0_0_0_1234_0000_0000);
    run(60'h0_0_0_5678_0000_1234);
    run(60'h0_1_0_ABCD_0000_0000);
    run(60'h0_3_0_1111_0000_0000);
    run(60'h0_0_0_0000_0000_5678);
    $display("save and load test done");
  endtask
  task automatic t_round;
    run(60'h5_0_0_0000_0000_0000);
    run(60'h2_0_1_0000_0001_0000);
    run(60'h1_0_1_0000_0002_0002);
    run(60'h1_0_0_0000_0001_0002);
    run(60'h3_0_1_0000_FFFD_FFFF);
    run(60'h1_0_1_0000_7FFF_FFFF);
    run(60'h2_0_1_0000_7FFF_7FFE);
    run(60'h3_0_1_0000_7FFF_7FFF);
    $display("round test done");
  endtask
  task automatic t_mult;
    run(60'h7_0_0_1234_0000_0000);
    run(60'h5_0_0_4000_4000_0800);
    run(60'h6_0_0_4000_4000_1001);
    run(60'h3_0_1_0000_7FFF_7FFF);
    run(60'h6_0_0_4000_4000_7FFF);
    run(60'h7_0_0_8000_4000_0000);
    run(60'h8_0_0_8000_8000_1000);
    $display("fraction multiply test done");
  endtask
  task automatic t_quant;
    run(60'h9_0_0_0003_0010_0001);
    run(60'h9_0_0_FFFD_0010_FFFF);
    run(60'h9_0_0_7FFF_7FFF_07FF);
    run(60'h9_0_0_8000_7FFF_F800);
    $display("quantize test done");
  endtask
  // Halfword loads feed the shared byte accumulators
  task automatic t_bytes;
    run(60'h0_0_0_0000_0000_C000);
    run(60'h0_1_0_0300_0000_8000);
    run(60'h0_2_0_00FF_0000_0000);
    run(60'h4_1_0_0000_0000_0280);
    run(60'h4_0_0_0000_0000_0280);
    run(60'h0_0_0_0001_0000_0000);
    run(60'h0_1_0_FF80_0000_0200);
    run(60'h4_0_0_0000_0000_FF00);
    $display("byte round test done");
  endtask
  task automatic t_order;
    issue(4'h5, 4'hA, 1'b0, 16'h4000, {80'h0, 16'h4000, 32'h0}, 5'h15);
    issue(4'h6, 4'hA, 1'b0, 16'h4000, {80'h0, 16'h4000, 32'h0}, 5'h16);
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    peek(5'h15, {8{16'h0800}});
    peek(5'h16, {8{16'h1001}});
    $display("back to back test done");
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_save();
    t_round();
    t_mult();
    t_quant();
    t_bytes();
    t_order();
    results();
  end
endmodule
